// ===== ivr_map.vh
// constants for the interrupt vector resolver
// assumes a 20-bit code address space and a 32-bit apb register bus
`ifndef IVR_MAP_VH
`define IVR_MAP_VH

// ----------------------------------------------------------------------
// fixed vector table entries
// ----------------------------------------------------------------------
`define VEC_UNDEF     20'hFFFDC
`define VEC_OVERFLOW  20'hFFFE0
`define VEC_BREAK     20'hFFFE4
`define VEC_BRK_TEST  20'hFFFE6
`define VEC_ADDRMATCH 20'hFFFE8
`define VEC_STEP      20'hFFFEC
`define VEC_WATCHDOG  20'hFFFF0
`define VEC_DEBUG     20'hFFFF4
`define VEC_NMI       20'hFFFF8
`define VEC_RESET     20'hFFFFC
`define BRK_REDIRECT  8'hFF
`define VEC_BYTES     3'h4
`define RELOC_BYTES   9'h100
`define PERIPH_MASK   64'h180F_FE00_FFFF_FFFC

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define REG_CTRL      12'h000
`define REG_BASE      12'h004
`define REG_PEND      12'h008
`define REG_LVL_LO    12'h00C
`define REG_LVL_HI    12'h010
`define REG_LVL_CNT   4'h8
`define REG_SEL       12'h014
`define REG_AM_EN     12'h018
`define REG_AM_CMP0   12'h01C
`define REG_STATUS    12'h02C
`define REG_BRKBYTE   12'h030

// ----------------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------------
`define CTRL_IFLAG    0
`define CTRL_OFLAG    1
`define CTRL_UFLAG    2
`define CTRL_IPL_LSB  4
`define RST_CTRL      32'h0000_0000
`define RST_BASE      20'h00000
`define RST_BRKBYTE   8'h00

`endif

// ===== interrupt_vector_resolver.v
// interrupt vector resolver: classifies sources, resolves vector address
// assumes the core sequencer presents events on instruction boundaries and
// takes the resolved vector on the accept pulse
`timescale 1ns/1ps
`include "ivr_map.vh"

// How it works
// RQ1: vector is four bytes holding handler
// RQ2: fixed table FFFDCh to FFFFFh, reset last
// RQ3: undefined opcode trap uses FFFDCh
// RQ4: overflow trap fires only when flag set
// RQ5: breakpoint FFFE4h, FFh byte redirects relocatable
// RQ6: trap numbers 0..63 non-maskable, relocatable
// RQ7: some trap numbers share peripheral vectors
// RQ8: numbers 0..31 stack and clear stack flag
// RQ9: numbers 32..63 keep stack flag
// RQ10: nmi pin falling edge uses FFFF8h
// RQ11: special interrupts ignore enable and priority
// RQ12: software avoids single-step and debugger entries
// RQ13: watchdog, osc, voltage share FFFF0h
// RQ14: watchdog handler refreshes the watchdog
// RQ15: address match fires before matching instruction
// RQ16: peripheral requests maskable, relocatable vectors
// RQ17: relocatable table 256 bytes, base plus 4n
// RQ18: even base completes sequence faster
// RQ19: inputs 7,6,3 use numbers 2,3,4; code maps input n to number n
// RQ20: numbers 6,7 source chosen by select
// RQ21: numbers 8,9 serial or external by select
// RQ22: accept needs enable, request, level above ipl
// RQ23: request sets, clears on accept, sw clear; code clears by software only numbers 0..31
// RQ24: non-maskable resolved before maskable requests
module interrupt_vector_resolver #(
    parameter NUM_SRC = 64,
    parameter SEQ_FAST = 18,
    parameter SEQ_SLOW = 20
) (
    // clock and reset
    input  wire        sys_clk_in,
    input  wire        rst_n_in,
    // apb slave
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [11:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out,
    // core sequencer events, one-cycle pulses at instruction boundary
    input  wire        boundary_in,
    input  wire        undef_trap_in,
    input  wire        ovf_trap_in,
    input  wire        brk_instr_in,
    input  wire        int_instr_in,
    input  wire [5:0]  int_num_in,
    input  wire [19:0] next_pc_in,
    // special and peripheral sources
    input  wire        nmi_pin_in,
    input  wire        special_evt_in,
    input  wire [63:0] periph_req_in,
    // resolved interrupt toward the core
    output reg         accept_out,
    output reg  [19:0] vector_addr_out,
    output reg  [5:0]  vector_num_out,
    output reg         vector_reloc_out,
    output reg         push_uflag_out,
    output reg  [2:0]  new_ipl_out,
    output reg  [4:0]  seq_cycles_out
);

// ----------------------------------------------------------------------
// registers and state
// ----------------------------------------------------------------------
reg         iflag;
reg         oflag;
reg         uflag;
reg  [2:0]  processor_priority_level;
reg  [19:0] base;
reg  [63:0] pend;
reg  [2:0]  lvl [0:15];
reg  [3:0]  src_sel;
reg  [3:0]  am_en;
reg  [19:0] am_cmp [0:3];
reg  [7:0]  brk_byte;
reg  [1:0]  nmi_sync;
reg         nmi_prev;
reg         nmi_pend;
reg  [63:0] accept_clr;
reg  [63:0] raw_req;

integer     i, j, k;

// address of a relocatable entry, base plus four times the number [RQ17]
function [19:0] reloc_addr;
    input [19:0] b;
    input [5:0]  n;
    begin
        reloc_addr = b + {12'h000, n, 2'b00};
    end
endfunction

// level of relocatable number, sixteen groups of four numbers
function [2:0] level_of;
    input [5:0] n;
    begin
        level_of = lvl[n[5:2]];
    end
endfunction

// ----------------------------------------------------------------------
// source routing for shared numbers
// ----------------------------------------------------------------------
// raw_req bit n is the request for relocatable number n [RQ19]
always @* begin
    raw_req = periph_req_in & `PERIPH_MASK; // reserved numbers stay idle
    // select bit chooses alternate source on shared slots [RQ20] [RQ21]
    raw_req[6] = src_sel[0] ? periph_req_in[1]  : periph_req_in[6];
    raw_req[7] = src_sel[1] ? periph_req_in[32] : periph_req_in[7];
    raw_req[8] = src_sel[2] ? periph_req_in[33] : periph_req_in[8];
    raw_req[9] = src_sel[3] ? periph_req_in[34] : periph_req_in[9];
end

// ----------------------------------------------------------------------
// arbitration
// ----------------------------------------------------------------------
reg         nmi_edge;
reg         am_hit;
reg         mask_found;
reg  [5:0]  mask_num;
reg  [2:0]  mask_lvl;

always @* begin
    nmi_edge = nmi_prev & ~nmi_sync[1]; // high to low [RQ10]
    am_hit = 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
        if (am_en[i] && am_cmp[i] == next_pc_in) begin
            am_hit = 1'b1; // [RQ15]
        end
    end
    mask_found = 1'b0;
    mask_num = 6'h00;
    mask_lvl = 3'h0;
    // highest level wins, lower number on tie [RQ22]
    for (i = NUM_SRC - 1; i >= 0; i = i - 1) begin
        if (pend[i] && level_of(i[5:0]) > processor_priority_level
                && level_of(i[5:0]) >= mask_lvl) begin
            mask_found = 1'b1;
            mask_num = i[5:0];
            mask_lvl = level_of(i[5:0]);
        end
    end
end

// ----------------------------------------------------------------------
// resolve and accept on instruction boundary
// ----------------------------------------------------------------------
reg        hit;
reg        hit_reloc;
reg [19:0] hit_addr;
reg [5:0]  hit_num;
reg        hit_push;
reg [2:0]  hit_ipl;
reg        hit_mask;

// special and trap sources ahead of maskable ones [RQ24] [RQ11]
always @* begin
    hit = 1'b1;
    hit_reloc = 1'b0;
    hit_addr = `VEC_RESET;
    hit_num = 6'h00;
    hit_push = 1'b1; // accepted sequences clear stack flag, except trap numbers 32..63 [RQ8]
    hit_ipl = processor_priority_level;
    hit_mask = 1'b0;
    if (undef_trap_in) begin
        hit_addr = `VEC_UNDEF; // [RQ3]
    end else if (ovf_trap_in && oflag) begin
        hit_addr = `VEC_OVERFLOW; // [RQ4]
    end else if (brk_instr_in) begin
        if (brk_byte == `BRK_REDIRECT) begin
            hit_reloc = 1'b1;
            hit_addr = reloc_addr(base, 6'h00); // [RQ5]
        end else begin
            hit_addr = `VEC_BREAK; // [RQ5]
        end
    end else if (int_instr_in) begin
        // any number, shared ones reach peripheral handler [RQ6] [RQ7]
        hit_reloc = 1'b1;
        hit_num = int_num_in;
        hit_addr = reloc_addr(base, int_num_in);
        hit_push = ~int_num_in[5]; // [RQ8] [RQ9]
    end else if (nmi_edge || nmi_pend) begin
        hit_addr = `VEC_NMI; // [RQ10]
    end else if (special_evt_in) begin
        hit_addr = `VEC_WATCHDOG; // [RQ13]
    end else if (am_hit) begin
        hit_addr = `VEC_ADDRMATCH; // [RQ15]
    end else if (iflag && mask_found) begin
        hit_reloc = 1'b1; // [RQ16]
        hit_num = mask_num;
        hit_addr = reloc_addr(base, mask_num);
        hit_ipl = mask_lvl;
        hit_mask = 1'b1;
    end else begin
        hit = 1'b0;
    end
end

// outputs to core, vector address is start of a four-byte entry [RQ1]
always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
        accept_out <= 1'b0;
        vector_addr_out <= `VEC_RESET; // [RQ2]
        vector_num_out <= 6'h00;
        vector_reloc_out <= 1'b0;
        push_uflag_out <= 1'b0;
        new_ipl_out <= 3'h0;
        seq_cycles_out <= 5'h00;
        accept_clr <= 64'h0;
    end else begin
        accept_out <= boundary_in & hit;
        accept_clr <= 64'h0;
        if (boundary_in && hit) begin
            vector_addr_out <= hit_addr;
            vector_num_out <= hit_num;
            vector_reloc_out <= hit_reloc;
            push_uflag_out <= hit_push;
            new_ipl_out <= hit_ipl;
            // odd base costs more cycles [RQ18]
            seq_cycles_out <= (hit_reloc && base[0])
                ? SEQ_SLOW[4:0] : SEQ_FAST[4:0];
            if (hit_mask) begin
                accept_clr[mask_num] <= 1'b1; // [RQ23]
            end
        end
    end
end

// ----------------------------------------------------------------------
// nmi pin synchroniser
// ----------------------------------------------------------------------
always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
        nmi_sync <= 2'b11;
        nmi_prev <= 1'b1;
        nmi_pend <= 1'b0;
    end else begin
        nmi_sync <= {nmi_sync[0], nmi_pin_in};
        nmi_prev <= nmi_sync[1];
        nmi_pend <= (boundary_in && hit && !hit_reloc
            && hit_addr == `VEC_NMI) ? (nmi_pend & nmi_edge)
            : (nmi_pend | nmi_edge); // held until taken [RQ10]
    end
end

// ----------------------------------------------------------------------
// apb register file
// ----------------------------------------------------------------------
wire apb_wr = psel_in & penable_in & pwrite_in;
wire apb_rd = psel_in & penable_in & ~pwrite_in;
wire wr_pend = apb_wr && paddr_in == `REG_PEND;

// request bits: set wins, accept clears, software write-0 clears bits 0..31 only [RQ23]
always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
        pend <= 64'h0;
    end else begin
        for (j = 0; j < 64; j = j + 1) begin
            if (raw_req[j]) begin
                pend[j] <= 1'b1;
            end else if (accept_clr[j]) begin
                pend[j] <= 1'b0;
            end else if (wr_pend && j < 32 && !pwdata_in[j]) begin
                pend[j] <= 1'b0;
            end
        end
    end
end

// control and configuration writes
always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
        iflag <= 1'b0;
        oflag <= 1'b0;
        uflag <= 1'b0;
        processor_priority_level <= 3'h0;
        base <= `RST_BASE;
        src_sel <= 4'h0;
        am_en <= 4'h0;
        brk_byte <= `RST_BRKBYTE;
        for (k = 0; k < 16; k = k + 1) begin
            lvl[k] <= 3'h0;
        end
        for (k = 0; k < 4; k = k + 1) begin
            am_cmp[k] <= 20'h00000;
        end
    end else begin
        if (accept_out) begin
            iflag <= 1'b0; // sequence disables maskables
            processor_priority_level <= new_ipl_out;
            if (push_uflag_out) begin
                uflag <= 1'b0; // [RQ8]
            end
        end else if (apb_wr) begin
            case (paddr_in)
                `REG_CTRL: begin
                    iflag <= pwdata_in[`CTRL_IFLAG];
                    oflag <= pwdata_in[`CTRL_OFLAG];
                    uflag <= pwdata_in[`CTRL_UFLAG];
                    processor_priority_level <= pwdata_in[`CTRL_IPL_LSB+2:`CTRL_IPL_LSB];
                end
                `REG_BASE: base <= pwdata_in[19:0];
                `REG_SEL: src_sel <= pwdata_in[3:0];
                `REG_AM_EN: am_en <= pwdata_in[3:0];
                `REG_BRKBYTE: brk_byte <= pwdata_in[7:0];
                `REG_LVL_LO: begin
                    for (k = 0; k < 8; k = k + 1) begin
                        lvl[k] <= pwdata_in[k*4 +: 3];
                    end
                end
                `REG_LVL_HI: begin
                    for (k = 0; k < 8; k = k + 1) begin
                        lvl[k+8] <= pwdata_in[k*4 +: 3];
                    end
                end
                default: begin
                    for (k = 0; k < 4; k = k + 1) begin
                        if (paddr_in == `REG_AM_CMP0 + k*4) begin
                            am_cmp[k] <= pwdata_in[19:0];
                        end
                    end
                end
            endcase
        end
    end
end

// read mux, zero-wait answer, error on unmapped address
always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
        prdata_out <= 32'h0000_0000;
        pready_out <= 1'b0;
        pslverr_out <= 1'b0;
    end else begin
        pready_out <= psel_in & ~penable_in;
        pslverr_out <= 1'b0;
        prdata_out <= 32'h0000_0000;
        if (psel_in && !penable_in) begin
            case (paddr_in)
                `REG_CTRL: prdata_out <= {25'h0, processor_priority_level, 1'b0,
                                          uflag, oflag, iflag};
                `REG_BASE: prdata_out <= {12'h000, base};
                `REG_PEND: prdata_out <= pend[31:0];
                `REG_SEL: prdata_out <= {28'h0, src_sel};
                `REG_AM_EN: prdata_out <= {28'h0, am_en};
                `REG_BRKBYTE: prdata_out <= {24'h0, brk_byte};
                `REG_STATUS: prdata_out <= pend[63:32];
                `REG_LVL_LO, `REG_LVL_HI: prdata_out <= 32'h0000_0000;
                `REG_AM_CMP0, `REG_AM_CMP0 + 12'h4,
                `REG_AM_CMP0 + 12'h8, `REG_AM_CMP0 + 12'hC:
                    prdata_out <= {12'h000,
                                   am_cmp[paddr_in[3:2] + 2'b01]};
                default: pslverr_out <= 1'b1;
            endcase
        end
    end
end

endmodule

// ===== ivr_props.sv
// concurrent checks on the interrupt vector resolver ports
// assumes it is bound onto the resolver top module
`timescale 1ns/1ps
`include "ivr_map.vh"
module ivr_props #(
    parameter SEQ_FAST = 18,
    parameter SEQ_SLOW = 20
) (
    // clock and reset
    input wire        sys_clk_in,
    input wire        rst_n_in,
    // core events
    input wire        boundary_in,
    input wire        undef_trap_in,
    input wire        ovf_trap_in,
    input wire        brk_instr_in,
    input wire        int_instr_in,
    input wire [5:0]  int_num_in,
    input wire        special_evt_in,
    // resolved interrupt
    input wire        accept_out,
    input wire [19:0] vector_addr_out,
    input wire [5:0]  vector_num_out,
    input wire        vector_reloc_out,
    input wire        push_uflag_out,
    input wire [4:0]  seq_cycles_out
);
    // ----------------------------------------------------------------
    // source qualifiers
    // ----------------------------------------------------------------
    wire no_hi  = boundary_in & ~undef_trap_in & ~ovf_trap_in;
    wire brk_on = no_hi & brk_instr_in;
    wire int_on = no_hi & ~brk_instr_in & int_instr_in;
    wire sp_on  = no_hi & ~brk_instr_in & ~int_instr_in & special_evt_in;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_reset_vec;
        $rose(rst_n_in) |-> vector_addr_out == `VEC_RESET;
    endproperty
    a_reset_vec: assert property (p_reset_vec)
        else $error("reset vector not shown");
    property p_undef;
        boundary_in && undef_trap_in |=> accept_out && !vector_reloc_out
            && vector_addr_out == `VEC_UNDEF;
    endproperty
    a_undef: assert property (p_undef)
        else $error("undefined opcode vector wrong");
    property p_brk;
        brk_on |=> accept_out && (vector_reloc_out ? vector_num_out == 6'h00
            : vector_addr_out == `VEC_BREAK);
    endproperty
    a_brk: assert property (p_brk)
        else $error("breakpoint vector wrong");
    property p_int;
        int_on |=> accept_out && vector_reloc_out
            && vector_num_out == $past(int_num_in);
    endproperty
    a_int: assert property (p_int)
        else $error("trap number not taken");
    property p_ustack;
        int_on |=> push_uflag_out == ($past(int_num_in) < 6'd32);
    endproperty
    a_ustack: assert property (p_ustack)
        else $error("stack select handling wrong");
    property p_special;
        sp_on |=> accept_out && (vector_addr_out == `VEC_WATCHDOG
            || vector_addr_out == `VEC_NMI);
    endproperty
    a_special: assert property (p_special)
        else $error("special event not taken");
    property p_seq;
        accept_out && vector_reloc_out |->
            seq_cycles_out == SEQ_FAST || seq_cycles_out == SEQ_SLOW;
    endproperty
    a_seq: assert property (p_seq)
        else $error("sequence length out of set");
    property p_stable;
        !accept_out |-> $stable(vector_addr_out) && $stable(vector_num_out);
    endproperty
    a_stable: assert property (p_stable)
        else $error("vector moved without accept");
    property p_cause;
        accept_out |-> $past(boundary_in);
    endproperty
    a_cause: assert property (p_cause)
        else $error("accept off a boundary");
endmodule

bind interrupt_vector_resolver ivr_props #(
    .SEQ_FAST(SEQ_FAST),
    .SEQ_SLOW(SEQ_SLOW)
) ivr_props_i (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .boundary_in(boundary_in), .undef_trap_in(undef_trap_in),
    .ovf_trap_in(ovf_trap_in), .brk_instr_in(brk_instr_in),
    .int_instr_in(int_instr_in), .int_num_in(int_num_in),
    .special_evt_in(special_evt_in), .accept_out(accept_out),
    .vector_addr_out(vector_addr_out), .vector_num_out(vector_num_out),
    .vector_reloc_out(vector_reloc_out), .push_uflag_out(push_uflag_out),
    .seq_cycles_out(seq_cycles_out)
);

// ===== core_seq_model.sv
// core sequencer and peripheral request model
// assumes the bench calls its tasks; all changes follow a rising edge
`timescale 1ns/1ps
module core_seq_model (
    // clock
    input  wire        sys_clk_in,
    // events toward the resolver
    output reg         boundary_out,
    output reg  [4:0]  kind_out,
    output reg  [5:0]  int_num_out,
    output reg  [19:0] next_pc_out,
    output reg         nmi_pin_out,
    output reg  [63:0] periph_req_out
);
    // quiet start, nmi pin idles high
    initial begin
        boundary_out = 1'b0;
        kind_out = 5'h00;
        int_num_out = 6'h00;
        next_pc_out = 20'h00000;
        nmi_pin_out = 1'b1;
        periph_req_out = 64'h0;
    end
    // one boundary; kind is undef, ovf, brk, trap, special
    // never raises single-step or debugger entries
    // watchdog events assume a handler that refreshes it
    task fire(input [4:0] k, input [5:0] n, input [19:0] pc);
        begin
            @(posedge sys_clk_in);
            boundary_out <= 1'b1;
            kind_out <= k;
            int_num_out <= n;
            next_pc_out <= pc;
            @(posedge sys_clk_in);
            boundary_out <= 1'b0;
            kind_out <= 5'h00;
            int_num_out <= ~n;
            next_pc_out <= ~pc;
        end
    endtask
    // one-cycle request on a line
    task pulse(input [5:0] n);
        begin
            @(posedge sys_clk_in);
            periph_req_out[n] <= 1'b1;
            @(posedge sys_clk_in);
            periph_req_out[n] <= 1'b0;
        end
    endtask
    task set_nmi(input v);
        begin
            @(posedge sys_clk_in);
            nmi_pin_out <= v;
        end
    endtask
endmodule

// ===== test_interrupt_vector_resolver.sv
// self-checking bench for the interrupt vector resolver
// assumes the core model drives events and apb tasks reach registers
`timescale 1ns/1ps
`include "ivr_map.vh"
module test_interrupt_vector_resolver;
    localparam fast_seq = 18;
    localparam slow_seq = 20;
    // apb master and clock
    reg         sys_clk_in;
    reg         rst_n_in;
    reg         psel_in;
    reg         penable_in;
    reg         pwrite_in;
    reg  [11:0] paddr_in;
    reg  [31:0] pwdata_in;
    wire [31:0] prdata_out;
    wire        pready_out;
    wire        pslverr_out;
    // core side
    wire        boundary;
    wire [4:0]  kind;
    wire [5:0]  num;
    wire [19:0] pc;
    wire        nmi;
    wire [63:0] req;
    wire        accept_out;
    wire [19:0] vector_addr_out;
    wire [5:0]  vector_num_out;
    wire        vector_reloc_out;
    wire        push_uflag_out;
    wire [2:0]  new_ipl_out;
    wire [4:0]  seq_cycles_out;
    integer     n_errors = 0;
    integer     n_compared = 0;
    integer     cyc = 0;
    integer     i;
    reg  [31:0] rd;
    reg         err;
    reg  [5:0]  n;
    reg  [19:0] base = 20'h01000;
    reg  [35:0] nums = {6'd0, 6'd2, 6'd31, 6'd32, 6'd40, 6'd63};

    always #5 sys_clk_in = ~sys_clk_in;

    interrupt_vector_resolver #(
        .SEQ_FAST(fast_seq),
        .SEQ_SLOW(slow_seq)
    ) interrupt_vector_resolver_i (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .boundary_in(boundary),
        .undef_trap_in(kind[4]), .ovf_trap_in(kind[3]),
        .brk_instr_in(kind[2]), .int_instr_in(kind[1]),
        .int_num_in(num), .next_pc_in(pc), .nmi_pin_in(nmi),
        .special_evt_in(kind[0]), .periph_req_in(req),
        .accept_out(accept_out), .vector_addr_out(vector_addr_out),
        .vector_num_out(vector_num_out),
        .vector_reloc_out(vector_reloc_out),
        .push_uflag_out(push_uflag_out), .new_ipl_out(new_ipl_out),
        .seq_cycles_out(seq_cycles_out)
    );
    core_seq_model core_seq_model_i (
        .sys_clk_in(sys_clk_in), .boundary_out(boundary), .kind_out(kind),
        .int_num_out(num), .next_pc_out(pc), .nmi_pin_out(nmi),
        .periph_req_out(req)
    );

    task summarize;
        begin
            if (n_errors == 0 && n_compared > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    // hang guard
    always @(posedge sys_clk_in) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            n_errors = n_errors + 1;
            summarize;
        end
    end
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("BAD %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // one apb transfer, held until pready
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge sys_clk_in);
            psel_in <= 1'b1;
            pwrite_in <= w;
            paddr_in <= a;
            pwdata_in <= d;
            @(posedge sys_clk_in);
            penable_in <= 1'b1;
            @(posedge sys_clk_in);
            while (pready_out !== 1'b1) @(posedge sys_clk_in);
            rd = prdata_out;
            err = pslverr_out;
            psel_in <= 1'b0;
            penable_in <= 1'b0;
        end
    endtask
    task rdchk(input [11:0] a, input [31:0] exp);
        begin
            apb(1'b0, a, 32'h0);
            chk(rd, exp);
        end
    endtask
    // accept seen one cycle after the boundary
    task acc(input a, input [19:0] v);
        begin
            #1;
            chk(accept_out, a);
            if (a) chk(vector_addr_out, v);
        end
    endtask

    initial begin
        sys_clk_in = 1'b0;
        rst_n_in = 1'b0;
        {psel_in, penable_in, pwrite_in} = 3'b000;
        paddr_in = 12'h000;
        pwdata_in = 32'h0000_0000;
        repeat (12) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        #1 chk(vector_addr_out, `VEC_RESET);
        apb(1'b1, `REG_BASE, {12'h000, base});
        rdchk(`REG_BASE, {12'h000, base});
        apb(1'b0, 12'hFFC, 32'h0);
        chk(err, 1'b1);
        core_seq_model_i.fire(5'h10, 6'h00, 20'h00000);
        acc(1'b1, `VEC_UNDEF);
        core_seq_model_i.fire(5'h08, 6'h00, 20'h00000);
        acc(1'b0, 20'h00000);
        apb(1'b1, `REG_CTRL, 32'h0000_0002);
        core_seq_model_i.fire(5'h08, 6'h00, 20'h00000);
        acc(1'b1, `VEC_OVERFLOW);
        core_seq_model_i.fire(5'h04, 6'h00, 20'h00000);
        acc(1'b1, `VEC_BREAK);
        apb(1'b1, `REG_BRKBYTE, {24'h0, `BRK_REDIRECT});
        core_seq_model_i.fire(5'h04, 6'h00, 20'h00000);
        acc(1'b1, base);
        // trap numbers across both stack halves
        for (i = 0; i < 6; i = i + 1) begin
            n = nums[i*6 +: 6];
            core_seq_model_i.fire(5'h02, n, 20'h00000);
            acc(1'b1, base + {n, 2'b00});
            chk(push_uflag_out, n < 6'd32);
            chk(seq_cycles_out, fast_seq);
        end
        apb(1'b1, `REG_BASE, 32'h0000_1001);
        core_seq_model_i.fire(5'h02, 6'd5, 20'h00000);
        acc(1'b1, 20'h01015);
        chk(seq_cycles_out, slow_seq);
        apb(1'b1, `REG_BASE, {12'h000, base});
        core_seq_model_i.fire(5'h01, 6'h00, 20'h00000);
        acc(1'b1, `VEC_WATCHDOG);
        core_seq_model_i.set_nmi(1'b0);
        repeat (4) @(posedge sys_clk_in);
        core_seq_model_i.fire(5'h00, 6'h00, 20'h00000);
        acc(1'b1, `VEC_NMI);
        core_seq_model_i.set_nmi(1'b1);
        apb(1'b1, `REG_AM_CMP0, 32'h0001_2340);
        apb(1'b1, `REG_AM_EN, 32'h0000_0001);
        core_seq_model_i.fire(5'h00, 6'h00, 20'h12341);
        acc(1'b0, 20'h00000);
        core_seq_model_i.fire(5'h00, 6'h00, 20'h12340);
        acc(1'b1, `VEC_ADDRMATCH);
        apb(1'b1, `REG_AM_EN, 32'h0000_0000);
        // maskable: level equal to ipl waits, above is taken
        apb(1'b1, `REG_LVL_LO, 32'h0000_0333);
        core_seq_model_i.pulse(6'd2);
        apb(1'b1, `REG_CTRL, 32'h0000_0031);
        core_seq_model_i.fire(5'h00, 6'h00, 20'h00000);
        acc(1'b0, 20'h00000);
        rdchk(`REG_PEND, 32'h0000_0004);
        apb(1'b1, `REG_CTRL, 32'h0000_0021);
        core_seq_model_i.fire(5'h00, 6'h00, 20'h00000);
        acc(1'b1, base + 20'd8);
        chk(new_ipl_out, 3'd3);
        rdchk(`REG_PEND, 32'h0000_0000);
        rdchk(`REG_CTRL, 32'h0000_0030);
        // trap beats pending request, software clear drops it
        core_seq_model_i.pulse(6'd2);
        apb(1'b1, `REG_CTRL, 32'h0000_0001);
        core_seq_model_i.fire(5'h10, 6'h00, 20'h00000);
        acc(1'b1, `VEC_UNDEF);
        apb(1'b1, `REG_PEND, 32'h0000_0000);
        apb(1'b1, `REG_CTRL, 32'h0000_0001);
        core_seq_model_i.fire(5'h00, 6'h00, 20'h00000);
        acc(1'b0, 20'h00000);
        // alternate sources by select bits
        apb(1'b1, `REG_SEL, 32'h0000_0005);
        core_seq_model_i.pulse(6'd33);
        core_seq_model_i.fire(5'h00, 6'h00, 20'h00000);
        acc(1'b1, base + 20'd32);
        apb(1'b1, `REG_CTRL, 32'h0000_0001);
        core_seq_model_i.pulse(6'd1);
        core_seq_model_i.fire(5'h00, 6'h00, 20'h00000);
        acc(1'b1, base + 20'd24);
        summarize;
    end
endmodule
